// file: rtl/hba_cfg.svh
// constants for the harvard bus arbiter and peripheral bridge
// Overview of operation
// R1 - program read bus: 22-bit address, 32-bit data
// R2 - data read/write buses: 32-bit address and data
// R3 - full 32-bit access in one bus cycle
// R4 - fetch, data read, data write run concurrently; memory port serves one per cycle, peripheral accesses overlap
// R5 - fixed priority: dwrite, pwrite, dread, pread, fetch
// R6 - requester never issues data and program write together
// R7 - requester never issues program read and fetch together
// R8 - bridge folds buses onto 16-bit-address peripheral bus
// R9 - second frame accepts only 16-bit accesses
// R10 - first frame accepts 16 and 32-bit accesses
// R11 - third frame: 16/32-bit, CPU and DMA
// R12 - first frame: writes 0-wait, reads 2-wait, stretchable
// R13 - back-to-back first-frame writes add one cycle
// R14 - second frame fixed timing, ready ignored
// R15 - losing requests stay pending until they win
`ifndef HBA_CFG_SVH
`define HBA_CFG_SVH
// bus widths
`define HBA_PA_W     22
`define HBA_DA_W     32
`define HBA_DW       32
`define HBA_PER_AW   16
`define HBA_PA_PAD   10'h000
`define HBA_HALF_PAD 16'h0000
// peripheral page decode: upper half of the data address
`define HBA_PER_PAGE 16'h0000
`define HBA_FRM_MSB  15
`define HBA_FRM_LSB  12
`define HBA_F1_ID    4'h6
`define HBA_F2_ID    4'h7
`define HBA_F3_ID    4'h5
// wait states on peripheral reads
`define HBA_RD_WAIT  2'h2
`define HBA_WAIT_ONE 2'h1
// memory source index, highest priority first
`define HBA_S_DW     0
`define HBA_S_PW     1
`define HBA_S_DR     2
`define HBA_S_PR     3
`define HBA_S_FE     4
`define HBA_NMEM     5
// peripheral source index
`define HBA_P_DW     0
`define HBA_P_DR     1
`define HBA_P_DMA    2
`define HBA_NPER     3
`endif

// file: rtl/hba_pkg.sv
// types shared by the arbiter bridge
package hba_pkg;
  // peripheral bus sequencer states, one-hot
  typedef enum logic [3:0] {
    PS_IDLE = 4'h1,
    PS_ACC  = 4'h2,
    PS_GAP  = 4'h4,
    PS_ERR  = 4'h8
  } hba_pstate_t;
endpackage : hba_pkg

// file: rtl/hba_fixed_prio.sv
// fixed-priority picker: index 0 wins
`timescale 1ns/100ps
module hba_fixed_prio #(
  parameter int N = 2
) (
  input  wire logic [N-1:0] req,
  output      logic [N-1:0] gnt
);
  // walk from highest priority down, first request found takes the grant
  always_comb begin
    logic taken;
    taken = 1'b0;
    gnt   = '0;
    for (int i = 0; i < N; i++) begin
      if (req[i] && !taken) begin
        gnt[i] = 1'b1;
        taken  = 1'b1;
      end
    end
  end
endmodule : hba_fixed_prio

// file: rtl/hba_bridge.sv
// memory-bus arbiter with peripheral bridge
`timescale 1ns/100ps
`include "hba_cfg.svh"
module hba_bridge
  import hba_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   ce,
  // cpu program bus (fetch, program read, program write share the address)
  input  wire logic                   fetchReq,
  input  wire logic                   progRdReq,
  input  wire logic                   progWrReq,
  input  wire logic [`HBA_PA_W-1:0]   progAddr,
  // cpu data read bus
  input  wire logic                   dataRdReq,
  input  wire logic [`HBA_DA_W-1:0]   dataRdAddr,
  input  wire logic                   dataRdWide,
  // cpu data write bus, also carries program write data
  input  wire logic                   dataWrReq,
  input  wire logic [`HBA_DA_W-1:0]   dataWrAddr,
  input  wire logic [`HBA_DW-1:0]     dataWrData,
  input  wire logic                   dataWrWide,
  // dma requester, peripheral third frame only
  input  wire logic                   dmaReq,
  input  wire logic                   dmaWrite,
  input  wire logic [`HBA_PER_AW-1:0] dmaAddr,
  input  wire logic [`HBA_DW-1:0]     dmaWrData,
  input  wire logic                   dmaWide,
  // completions back to requesters
  output      logic                   fetchDone_r,
  output      logic                   progRdDone_r,
  output      logic                   progWrDone_r,
  output      logic                   dataRdDone_r,
  output      logic                   dataWrDone_r,
  output      logic                   dmaDone_r,
  output      logic                   accErr_r,
  output      logic [`HBA_DW-1:0]     progRdData_r,
  output      logic [`HBA_DW-1:0]     dataRdData_r,
  output      logic [`HBA_DW-1:0]     dmaRdData_r,
  // attached memory, read data valid in the cycle of memEn_r
  output      logic                   memEn_r,
  output      logic                   memWe_r,
  output      logic [`HBA_DA_W-1:0]   memAddr_r,
  output      logic [`HBA_DW-1:0]     memWrData_r,
  input  wire logic [`HBA_DW-1:0]     memRdData,
  // peripheral bus
  output      logic                   perStrobe_r,
  output      logic [2:0]             perFrame_r,
  output      logic                   perWrite_r,
  output      logic                   perWide_r,
  output      logic [`HBA_PER_AW-1:0] perAddr_r,
  output      logic [`HBA_DW-1:0]     perWrData_r,
  input  wire logic [`HBA_DW-1:0]     perRdData,
  input  wire logic                   perReady
);
  ////////////////////////////////////////////////////////////////////////////
  // address decode
  logic                   rdIsPer;   // data read aims at peripheral page
  logic                   wrIsPer;   // data write aims at peripheral page
  logic [`HBA_NMEM-1:0]   memSrc_r;  // memory access in flight, by source
  logic [`HBA_NMEM-1:0]   memReq;    // eligible memory requests
  logic [`HBA_NMEM-1:0]   memGnt;    // memory winner this cycle
  logic [`HBA_NPER-1:0]   perReq;    // eligible peripheral requests
  logic [`HBA_NPER-1:0]   perGnt;    // peripheral winner this cycle
  hba_pstate_t            pState_r;  // peripheral sequencer state
  logic [`HBA_NPER-1:0]   perSrc_r;  // owner of the peripheral cycle
  logic [1:0]             waitCnt_r; // wait states spent so far
  logic                   f1WrLast_r;// last cycle finished a first-frame write
  logic                   perFin;    // peripheral access completes now
  logic                   pickWrite; // granted peripheral access is a write
  logic                   pickWide;  // granted peripheral access is 32-bit
  logic [`HBA_PER_AW-1:0] pickAddr;  // granted peripheral address
  logic [`HBA_DW-1:0]     pickData;  // granted peripheral write data
  logic [2:0]             pickFrm;   // granted frame, one-hot {f3,f2,f1}

  // R8 peripheral page decode
  assign rdIsPer = (dataRdAddr[`HBA_DA_W-1:`HBA_PER_AW] == `HBA_PER_PAGE);
  assign wrIsPer = (dataWrAddr[`HBA_DA_W-1:`HBA_PER_AW] == `HBA_PER_PAGE);

  ////////////////////////////////////////////////////////////////////////////
  // memory arbitration
  // a source is masked in flight and in its done cycle: a held request is taken once
  always_comb begin
    memReq[`HBA_S_DW] = dataWrReq && !wrIsPer && !dataWrDone_r;
    memReq[`HBA_S_PW] = progWrReq && !progWrDone_r;
    memReq[`HBA_S_DR] = dataRdReq && !rdIsPer && !memSrc_r[`HBA_S_DR] && !dataRdDone_r;
    memReq[`HBA_S_PR] = progRdReq && !memSrc_r[`HBA_S_PR] && !progRdDone_r;
    memReq[`HBA_S_FE] = fetchReq && !memSrc_r[`HBA_S_FE] && !fetchDone_r;
  end

  // R5 fixed priority order of the memory port
  hba_fixed_prio #(
    .N (`HBA_NMEM)
  ) u_memArb (
    .req (memReq),
    .gnt (memGnt)
  );

  // R15 losers are not recorded; their held request retries next cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memSrc_r    <= '0;
      memEn_r     <= 1'b0;
      memWe_r     <= 1'b0;
      memAddr_r   <= '0;
      memWrData_r <= '0;
    end else if (ce) begin
      memSrc_r <= memGnt;
      memEn_r  <= |memGnt;
      memWe_r  <= memGnt[`HBA_S_DW] || memGnt[`HBA_S_PW];
      // R6 program write data rides on the data write bus
      memWrData_r <= dataWrData;
      // R1 R2 program addresses zero extended, data addresses full
      if (memGnt[`HBA_S_DW])
        memAddr_r <= dataWrAddr;
      else if (memGnt[`HBA_S_DR])
        memAddr_r <= dataRdAddr;
      else
        memAddr_r <= {`HBA_PA_PAD, progAddr};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // peripheral arbitration and selection
  // only offered while the sequencer is idle; dma is lowest
  always_comb begin
    perReq = '0;
    if (pState_r == PS_IDLE) begin
      perReq[`HBA_P_DW]  = dataWrReq && wrIsPer && !dataWrDone_r;
      perReq[`HBA_P_DR]  = dataRdReq && rdIsPer && !dataRdDone_r;
      perReq[`HBA_P_DMA] = dmaReq && !dmaDone_r;
    end
  end

  hba_fixed_prio #(
    .N (`HBA_NPER)
  ) u_perArb (
    .req (perReq),
    .gnt (perGnt)
  );

  // R8 multiplex the winner onto the narrow bus
  always_comb begin
    pickWrite = 1'b0;
    pickWide  = dmaWide;
    pickAddr  = dmaAddr;
    pickData  = dmaWrData;
    if (perGnt[`HBA_P_DW]) begin
      pickWrite = 1'b1;
      pickWide  = dataWrWide;
      pickAddr  = dataWrAddr[`HBA_PER_AW-1:0];
      pickData  = dataWrData;
    end else if (perGnt[`HBA_P_DR]) begin
      pickWide  = dataRdWide;
      pickAddr  = dataRdAddr[`HBA_PER_AW-1:0];
    end else begin
      pickWrite = dmaWrite;
    end
    pickFrm[0] = (pickAddr[`HBA_FRM_MSB:`HBA_FRM_LSB] == `HBA_F1_ID);
    pickFrm[1] = (pickAddr[`HBA_FRM_MSB:`HBA_FRM_LSB] == `HBA_F2_ID);
    pickFrm[2] = (pickAddr[`HBA_FRM_MSB:`HBA_FRM_LSB] == `HBA_F3_ID);
  end

  // completion: writes no wait, reads two; ready stretches all but frame 2
  assign perFin = (pState_r == PS_ACC) &&
                  (perWrite_r || (waitCnt_r == `HBA_RD_WAIT)) &&
                  (perFrame_r[1] || perReady);

  ////////////////////////////////////////////////////////////////////////////
  // peripheral sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pState_r    <= PS_IDLE;
      perSrc_r    <= '0;
      perStrobe_r <= 1'b0;
      perFrame_r  <= '0;
      perWrite_r  <= 1'b0;
      perWide_r   <= 1'b0;
      perAddr_r   <= '0;
      perWrData_r <= '0;
      waitCnt_r   <= '0;
      f1WrLast_r  <= 1'b0;
    end else if (ce) begin
      case (pState_r)
        PS_IDLE: begin
          f1WrLast_r <= f1WrLast_r && dataWrDone_r; // writer is masked in done cycle, keep mark one more
          if (|perGnt) begin
            perSrc_r    <= perGnt;
            perFrame_r  <= pickFrm;
            perWrite_r  <= pickWrite;
            perWide_r   <= pickWide;
            perAddr_r   <= pickAddr;
            perWrData_r <= pickData;
            waitCnt_r   <= '0;
            // R9 R11 wide to second frame, dma outside third, or no frame
            if ((pickFrm[1] && pickWide) || (perGnt[`HBA_P_DMA] && !pickFrm[2]) || !(|pickFrm))
              pState_r <= PS_ERR;
            // R13 one extra cycle between first-frame writes
            else if (pickFrm[0] && pickWrite && f1WrLast_r)
              pState_r <= PS_GAP;
            else begin
              // R10 R11 both widths pass through here
              pState_r    <= PS_ACC;
              perStrobe_r <= 1'b1;
            end
          end
        end
        PS_GAP: begin
          pState_r    <= PS_ACC;
          perStrobe_r <= 1'b1;
        end
        PS_ACC: begin
          // R12 R14 wait states, stretched only where ready counts
          if (perFin) begin
            pState_r    <= PS_IDLE;
            perStrobe_r <= 1'b0;
            f1WrLast_r  <= perFrame_r[0] && perWrite_r;
          end else if (waitCnt_r != `HBA_RD_WAIT) begin
            waitCnt_r <= waitCnt_r + `HBA_WAIT_ONE;
          end
        end
        PS_ERR: begin // refused access ends without any bus cycle
          pState_r <= PS_IDLE;
        end
        default: begin
          pState_r    <= PS_IDLE;
          perStrobe_r <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // completions and read data
  // R3 R4 each bus has its own done path; the one memory port still grants one of them per cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetchDone_r  <= 1'b0;
      progRdDone_r <= 1'b0;
      progWrDone_r <= 1'b0;
      dataRdDone_r <= 1'b0;
      dataWrDone_r <= 1'b0;
      dmaDone_r    <= 1'b0;
      accErr_r     <= 1'b0;
    end else if (ce) begin
      dataWrDone_r <= memGnt[`HBA_S_DW] || ((perFin || pState_r == PS_ERR) && perSrc_r[`HBA_P_DW]);
      progWrDone_r <= memGnt[`HBA_S_PW];
      dataRdDone_r <= memSrc_r[`HBA_S_DR] || ((perFin || pState_r == PS_ERR) && perSrc_r[`HBA_P_DR]);
      progRdDone_r <= memSrc_r[`HBA_S_PR];
      fetchDone_r  <= memSrc_r[`HBA_S_FE];
      dmaDone_r    <= (perFin || pState_r == PS_ERR) && perSrc_r[`HBA_P_DMA];
      accErr_r     <= (pState_r == PS_ERR);
    end
  end

  // narrow peripheral reads return the low half with the upper half cleared, memory reads the whole word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      progRdData_r <= '0;
      dataRdData_r <= '0;
      dmaRdData_r  <= '0;
    end else if (ce) begin
      if (memSrc_r[`HBA_S_PR] || memSrc_r[`HBA_S_FE])
        progRdData_r <= memRdData;
      if (memSrc_r[`HBA_S_DR])
        dataRdData_r <= memRdData;
      else if (perFin && perSrc_r[`HBA_P_DR])
        dataRdData_r <= perWide_r ? perRdData : {`HBA_HALF_PAD, perRdData[15:0]};
      if (perFin && perSrc_r[`HBA_P_DMA])
        dmaRdData_r <= perWide_r ? perRdData : {`HBA_HALF_PAD, perRdData[15:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_mem_single: assert property (@(posedge clk) disable iff (!rst_n) $onehot0(memGnt)) // R4
    else $error("more than one memory grant");
  chk_dw_first: assert property (@(posedge clk) disable iff (!rst_n) memReq[0] |-> memGnt[0]) // R5
    else $error("data write lost memory arbitration");
  chk_fetch_last: assert property (@(posedge clk) disable iff (!rst_n) // R5
    memGnt[4] |-> (memReq[3:0] == 4'h0)) else $error("fetch granted over a higher request");
  chk_loser_waits: assert property (@(posedge clk) disable iff (!rst_n || !ce) // R15
    (memReq[4] && |memGnt[3:0]) |=> !memSrc_r[4] && !fetchDone_r) else $error("losing fetch was serviced");
  chk_read_latency: assert property (@(posedge clk) disable iff (!rst_n || !ce) // R3
    memGnt[2] |=> memEn_r && !memWe_r ##1 dataRdDone_r) else $error("data read not done two cycles after grant");
  chk_f2_narrow: assert property (@(posedge clk) disable iff (!rst_n) // R9
    perStrobe_r && perFrame_r[1] |-> !perWide_r) else $error("wide access on second frame");
  chk_dma_frame: assert property (@(posedge clk) disable iff (!rst_n) // R11
    perStrobe_r && perSrc_r[2] |-> perFrame_r[2]) else $error("dma outside third frame");
  chk_f2_read_time: assert property (@(posedge clk) disable iff (!rst_n || !ce) // R14
    $rose(perStrobe_r) && perFrame_r[1] && !perWrite_r |-> perStrobe_r[*3] ##1 !perStrobe_r)
    else $error("second frame read not three strobe cycles");
  chk_ready_stretch: assert property (@(posedge clk) disable iff (!rst_n || !ce) // R12
    perStrobe_r && !perFrame_r[1] && !perReady |=> perStrobe_r) else $error("stretched access ended without ready");
  chk_f1_gap: assert property (@(posedge clk) disable iff (!rst_n || !ce) // R13
    pState_r == PS_GAP |-> !perStrobe_r ##1 perStrobe_r && perWrite_r && perFrame_r[0])
    else $error("first frame write gap wrong");
endmodule : hba_bridge

// file: dv/hba_far_model.sv
// far-side model: attached memory and peripheral targets of the bridge
`timescale 1ns/100ps
`include "hba_cfg.svh"
module hba_far_model
  import hba_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [3:0]             stallCycles,
  input  wire logic                   memEn_r,
  input  wire logic [`HBA_DA_W-1:0]   memAddr_r,
  output      logic [`HBA_DW-1:0]     memRdData,
  input  wire logic                   perStrobe_r,
  input  wire logic [`HBA_PER_AW-1:0] perAddr_r,
  output      logic [`HBA_DW-1:0]     perRdData,
  output      logic                   perReady
);
  logic [3:0]         waitCnt_r;  // strobe cycles seen in this access
  logic [`HBA_DW-1:0] memLast_r;  // last word on the memory read lines
  logic [`HBA_DW-1:0] perLast_r;  // last word on the peripheral read lines

  ////////////////////////////////////////////////////////////////////////
  // count cycles of the current peripheral access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt_r <= 4'h0;
    end else begin
      waitCnt_r <= perStrobe_r ? waitCnt_r + 4'h1 : 4'h0;
    end
  end

  // idle read lines flip every cycle so a stale sample never looks valid
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memLast_r <= 32'h0000_0000;
      perLast_r <= 32'h0000_0000;
    end else begin
      memLast_r <= memRdData;
      perLast_r <= perRdData;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // memory answers in strobe cycle
  assign memRdData = memEn_r ? (memAddr_r ^ 32'hA5A5_5A5A) : ~memLast_r;
  assign perRdData = perStrobe_r ? {~perAddr_r, perAddr_r} : ~perLast_r;
  assign perReady  = perStrobe_r && (waitCnt_r >= stallCycles);
endmodule : hba_far_model

// file: dv/hba_bridge_tb_top.sv
// self-checking testbench for the arbiter bridge
`timescale 1ns/100ps
`include "hba_cfg.svh"
module hba_bridge_tb_top
  import hba_pkg::*;
();
  logic        clk, rst_n, ce, fetchReq, progRdReq, progWrReq, dataRdReq, dataRdWide;
  logic        dataWrReq, dataWrWide, dmaReq, dmaWrite, dmaWide, perReady, accErr_r;
  logic        fetchDone_r, progRdDone_r, progWrDone_r, dataRdDone_r, dataWrDone_r, dmaDone_r;
  logic        memEn_r, memWe_r, perStrobe_r, perWrite_r, perWide_r;
  logic [21:0] progAddr;
  logic [15:0] dmaAddr, perAddr_r;
  logic [2:0]  perFrame_r;
  logic [3:0]  stallCycles;
  logic [31:0] dataRdAddr, dataWrAddr, dataWrData, dmaWrData, progRdData_r, dataRdData_r;
  logic [31:0] dmaRdData_r, memAddr_r, memWrData_r, memRdData, perWrData_r, perRdData;
  int          errorCnt, numChecks;

  hba_bridge uut (.clk(clk), .rst_n(rst_n), .ce(ce), .fetchReq(fetchReq), .progRdReq(progRdReq),
    .progWrReq(progWrReq), .progAddr(progAddr), .dataRdReq(dataRdReq), .dataRdAddr(dataRdAddr),
    .dataRdWide(dataRdWide), .dataWrReq(dataWrReq), .dataWrAddr(dataWrAddr), .dataWrData(dataWrData),
    .dataWrWide(dataWrWide), .dmaReq(dmaReq), .dmaWrite(dmaWrite), .dmaAddr(dmaAddr),
    .dmaWrData(dmaWrData), .dmaWide(dmaWide), .fetchDone_r(fetchDone_r), .progRdDone_r(progRdDone_r),
    .progWrDone_r(progWrDone_r), .dataRdDone_r(dataRdDone_r), .dataWrDone_r(dataWrDone_r),
    .dmaDone_r(dmaDone_r), .accErr_r(accErr_r), .progRdData_r(progRdData_r),
    .dataRdData_r(dataRdData_r), .dmaRdData_r(dmaRdData_r), .memEn_r(memEn_r), .memWe_r(memWe_r),
    .memAddr_r(memAddr_r), .memWrData_r(memWrData_r), .memRdData(memRdData),
    .perStrobe_r(perStrobe_r), .perFrame_r(perFrame_r), .perWrite_r(perWrite_r),
    .perWide_r(perWide_r), .perAddr_r(perAddr_r), .perWrData_r(perWrData_r),
    .perRdData(perRdData), .perReady(perReady));

  hba_far_model far (.clk(clk), .rst_n(rst_n), .stallCycles(stallCycles), .memEn_r(memEn_r),
    .memAddr_r(memAddr_r), .memRdData(memRdData), .perStrobe_r(perStrobe_r),
    .perAddr_r(perAddr_r), .perRdData(perRdData), .perReady(perReady));

  ////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    numChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic final_report();
    if (errorCnt == 0 && numChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  // memory contention: each request held until its done, order of grants recorded
  task automatic mem_order(input logic [4:0] reqs, input logic [32:0] exp [3]);
    logic [4:0] live, done;
    int         k;
    k = 0;
    live = reqs;
    done = 5'h00;
    for (int c = 0; c < 8; c++) begin
      step();
      // requester never pairs the two writes, nor program read with fetch
      live = live & ~done;
      {fetchReq, progRdReq, dataRdReq, progWrReq, dataWrReq} = live;
      done = {fetchDone_r, progRdDone_r, dataRdDone_r, progWrDone_r, dataWrDone_r};
      if (memEn_r === 1'b1 && k < 3) begin
        chk({31'h0, memWe_r}, {31'h0, exp[k][32]}, "mem write flag");
        chk(memAddr_r, exp[k][31:0], "mem address order");
        if (memWe_r === 1'b1) begin
          chk(memWrData_r, dataWrData, "mem write data");
          chk({31'h0, dataWrDone_r | progWrDone_r}, 32'h1, "write done with strobe");
        end
        k++;
      end
    end
    chk(k, 3, "grant count");
  endtask : mem_order

  function automatic logic src_done(input int src);
    return src == 0 ? dataWrDone_r : (src == 1 ? dataRdDone_r : dmaDone_r);
  endfunction : src_done

  // one peripheral access from source src: 0 data write, 1 data read, 2 dma
  task automatic per_op(input int src, input logic wr, input logic [15:0] a, input logic wide,
                        input logic [3:0] st, input logic [2:0] frm, input logic err, input int len);
    int          n;
    logic [31:0] rd;
    n = 0;
    step();
    stallCycles = st;
    dataWrAddr = {16'h0000, a};
    dataRdAddr = {16'h0000, a};
    dmaAddr = a;
    dataWrWide = wide;
    dataRdWide = wide;
    dmaWide = wide;
    dmaWrite = wr;
    dataWrReq = (src == 0);
    dataRdReq = (src == 1);
    dmaReq = (src == 2);
    for (int c = 0; c < 14; c++) begin
      step();
      if (perStrobe_r === 1'b1) begin
        n++;
        chk({perFrame_r, perWrite_r, perWide_r, perAddr_r}, {11'h0, frm, wr, wide, a}, "per fields");
        if (wr && wide) begin
          chk(perWrData_r, src == 0 ? dataWrData : dmaWrData, "per write data");
        end
      end
      if (src_done(src) === 1'b1) begin
        break;
      end
    end
    chk({31'h0, src_done(src)}, 32'h1, "per done");
    chk({31'h0, accErr_r}, {31'h0, err}, "per refusal");
    chk(n, err ? 0 : len, "strobe length");
    rd = (src == 1) ? dataRdData_r : dmaRdData_r;
    if (!wr && !err) begin
      chk(rd, wide ? {~a, a} : {16'h0000, a}, "per read data");
    end
    step();
    {dataWrReq, dataRdReq, dmaReq} = 3'b000;
  endtask : per_op

  // fetch to memory and a peripheral write side by side
  task automatic concurrent();
    step();
    progAddr = 22'h00_0100;
    dataWrAddr = 32'h0000_6060;
    dataWrWide = 1'b1;
    stallCycles = 4'h0;
    fetchReq = 1'b1;
    dataWrReq = 1'b1;
    step();
    chk({30'h0, memEn_r, perStrobe_r}, 32'h3, "both buses active");
    step();
    chk({30'h0, fetchDone_r, dataWrDone_r}, 32'h3, "both done");
    step();
    {fetchReq, dataWrReq} = 2'b00;
  endtask : concurrent

  // back-to-back first-frame writes, the first one frozen a cycle by the clock enable
  task automatic f1_b2b();
    step();
    stallCycles = 4'h0;
    dataWrWide = 1'b0;
    dataWrAddr = 32'h0000_6070;
    dataWrReq = 1'b1;
    step();
    chk({31'h0, perStrobe_r}, 32'h1, "first write strobe");
    ce = 1'b0;
    step();
    chk({30'h0, perStrobe_r, dataWrDone_r}, 32'h2, "held while clock enable low");
    ce = 1'b1;
    step();
    chk({31'h0, dataWrDone_r}, 32'h1, "first write done");
    // writer follows up at once, request kept high with the next address
    dataWrAddr = 32'h0000_6072;
    step();
    step();
    chk({31'h0, perStrobe_r}, 32'h0, "pipeline gap cycle");
    step();
    chk({15'h0, perStrobe_r, perAddr_r}, 32'h0001_6072, "second write strobe");
    step();
    chk({31'h0, dataWrDone_r}, 32'h1, "second write done");
    step();
    dataWrReq = 1'b0;
  endtask : f1_b2b

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {fetchReq, progRdReq, progWrReq, dataRdReq, dataRdWide, dataWrReq, dataWrWide} = 7'h00;
    {dmaReq, dmaWrite, dmaWide} = 3'h0;
    {rst_n, ce, stallCycles, progAddr, dmaAddr} = {1'b0, 1'b1, 4'h0, 22'h00_0000, 16'h0000};
    {dataRdAddr, dataWrAddr} = {32'h0002_0080, 32'h0001_0040};
    {dataWrData, dmaWrData} = {32'hDEAD_BEEF, 32'h1234_5678};
    {errorCnt, numChecks} = {32'h0, 32'h0};
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    step();
    chk({29'h0, memEn_r, perStrobe_r, dataWrDone_r}, 32'h0, "idle after reset");
    progAddr = 22'h3F_FFFF;
    mem_order(5'b01101, '{33'h1_0001_0040, 33'h0_0002_0080, 33'h0_003F_FFFF});
    chk(dataRdData_r, 32'h0002_0080 ^ 32'hA5A5_5A5A, "data read word");
    chk(progRdData_r, 32'h003F_FFFF ^ 32'hA5A5_5A5A, "program read word");
    progAddr = 22'h12_3456;
    mem_order(5'b10110, '{33'h1_0012_3456, 33'h0_0002_0080, 33'h0_0012_3456});
    per_op(0, 1'b1, 16'h6010, 1'b1, 4'h0, 3'b001, 1'b0, 1);
    per_op(1, 1'b0, 16'h6020, 1'b1, 4'h0, 3'b001, 1'b0, 3);
    per_op(1, 1'b0, 16'h6022, 1'b0, 4'h4, 3'b001, 1'b0, 5);
    per_op(0, 1'b1, 16'h6030, 1'b0, 4'h3, 3'b001, 1'b0, 4);
    per_op(0, 1'b1, 16'h7040, 1'b0, 4'h4, 3'b010, 1'b0, 1);
    per_op(1, 1'b0, 16'h7042, 1'b0, 4'h5, 3'b010, 1'b0, 3);
    per_op(0, 1'b1, 16'h7044, 1'b1, 4'h0, 3'b010, 1'b1, 0);
    per_op(1, 1'b0, 16'h7046, 1'b1, 4'h0, 3'b010, 1'b1, 0);
    per_op(2, 1'b0, 16'h5050, 1'b1, 4'h0, 3'b100, 1'b0, 3);
    per_op(2, 1'b1, 16'h5052, 1'b0, 4'h2, 3'b100, 1'b0, 3);
    per_op(2, 1'b1, 16'h6054, 1'b1, 4'h0, 3'b001, 1'b1, 0);
    f1_b2b();
    concurrent();
    final_report();
  end

  // watchdog well beyond the hundred or so cycles the run needs
  initial begin
    #(5000 * 40);
    errorCnt++;
    $display("CHECK FAILED t=%0t run did not finish", $time);
    final_report();
  end
endmodule : hba_bridge_tb_top
